// File: usfc_top.sv
// usfc_top: transaction status fifo, usb control bits, frame threshold and table page
// assumes the packet engine pulses xfer_done once per finished transfer on clk
// assumes host_mode and table_base_upper are steady levels from the clk domain
// assumes a wishbone master that holds each request until it sees ack
//
// Function
// - status entry bits 7..4 hold the endpoint number of the finished transfer.
// - status bit 3 is 1 for transmit, 0 for receive.
// - status bit 2 is 1 for odd bank, 0 for even bank.
// - four-entry status fifo; status register shows the oldest entry.
// - status contents are valid only while the transaction done flag is set.
// - clearing the transaction done flag pops the status fifo.
// - writing 1 to control bit 1 resets all bank pointers to even.
// - in device mode control bit 0 enables the usb module.
// - in host mode frame marker enable sends a frame token every millisecond.
// - in host mode clearing resume appends a low-speed end of packet.
// - bits 31..8 of status, threshold and page registers read zero, ignore writes.
// - page bits 7..1 supply table base address bits 15..9; bit 0 reads zero.
// - table base address is 512-byte aligned; low nine bits are zero.
`timescale 1ns/1ps

module usfc_top
    import usfc_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_CYCLES,
    parameter int DEPTH     = FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // packet engine side
    input  wire logic        host_mode,
    input  wire logic        xfer_done,
    input  wire usfc_xfer_t  xfer_info,
    input  wire logic [15:0] table_base_upper,
    output logic             status_fifo_full,
    output logic             transaction_done_flag,
    output logic             module_enable,
    output logic             bank_pointer_reset,
    output logic             frame_marker_pulse,
    output logic             start_allowed,
    output logic             resume_active,
    output logic             ls_eop_active,
    output logic [31:0]      table_base_addr
);

    // pointer, frame timer and end of packet counter widths
    localparam int PW = $clog2(DEPTH);
    localparam int FW = $clog2(FRAME_LEN + 1);
    localparam int EW = $clog2(LS_EOP_CYCLES + 1);

    // storage and pointers
    usfc_stat_t     fifo_mem [DEPTH];
    logic [PW-1:0]  rd_ptr_r;
    logic [PW-1:0]  wr_ptr_r;
    logic [PW:0]    count_r;

    // registers
    logic [7:0]     ctrl_r;
    logic [7:0]     thresh_r;
    logic [7:0]     page_r;
    logic           ack_r;
    logic [31:0]    dat_r;
    logic           bank_rst_r;
    logic [FW-1:0]  frame_cnt_r;
    logic           sof_r;
    logic [EW-1:0]  eop_cnt_r;

    // decoded bus terms and other combinational terms
    logic           bus_req;
    logic           wr_take;
    logic           push;
    logic           pop;
    logic           flag_clear;
    logic           sof_on;
    logic           wr_ctrl;
    logic           wr_thresh;
    logic           wr_page;
    logic           resume_drop;
    logic [31:0]    guard_cycles;
    logic [31:0]    frame_left;
    logic [7:0]     rd_byte;
    usfc_stat_t     head;
    usfc_stat_t     new_entry;

    // word decode; byte lanes inside a word do not select registers
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // wraps explicitly so a depth that is not a power of two still works
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    // cyc and stb together make a request; sel only gates writes
    assign bus_req = wb_cyc_i && wb_stb_i;
    // writes land on the edge where the master sees ack, never earlier
    assign wr_take = bus_req && wb_we_i && ack_r && wb_sel_i[0];
    assign wr_ctrl   = wr_take && hit(wb_adr_i, CTRL_OFS);
    assign wr_thresh = wr_take && hit(wb_adr_i, THRESH_OFS);
    assign wr_page   = wr_take && hit(wb_adr_i, PAGE_OFS);

    // software clears the done flag by writing 1 to its bit
    assign flag_clear = wr_take && hit(wb_adr_i, FLAGS_OFS) && wb_dat_i[FLAG_TRN_BIT];
    // a clear on an empty fifo is ignored rather than wrapping the pointers
    assign pop        = flag_clear && (count_r != '0);
    // a full fifo refuses the new entry unless a flag clear pops in the same cycle; the engine should hold off on status_fifo_full
    assign push       = xfer_done && (count_r != (PW+1)'(DEPTH) || pop);

    // unused low status bits stay zero
    always_comb begin
        new_entry                      = '0;
        new_entry.last_endpoint_number = xfer_info.endpoint;
        new_entry.last_direction       = xfer_info.tx;
        new_entry.last_bank_indicator  = xfer_info.odd;
    end

    // the oldest entry is always on view; it means nothing while the flag is low
    assign head = fifo_mem[rd_ptr_r];

    // fifo storage, written in completion order
    // storage has no reset; it is only read behind a set done flag
    always_ff @(posedge clk) begin
        if (ce && push) begin
            fifo_mem[wr_ptr_r] <= new_entry;
        end
    end

    // fifo pointers; a push that meets a pop keeps the flag set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            count_r  <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= count_r + (PW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (PW+1)'(1);
            end
        end
    end

    // flag and full come straight from the count, so they can never disagree
    assign transaction_done_flag = (count_r != '0);
    assign status_fifo_full      = (count_r == (PW+1)'(DEPTH));

    // control register; bank pointer reset is write-only and reads back 0
    // the reset is a one-cycle pulse, so writing 0 leaves the bank pointers alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r     <= CTRL_RST;
            bank_rst_r <= 1'b0;
        end else if (ce) begin
            bank_rst_r <= 1'b0;
            if (wr_ctrl) begin
                ctrl_r[CTRL_EN_BIT]     <= wb_dat_i[CTRL_EN_BIT];
                ctrl_r[CTRL_RESUME_BIT] <= wb_dat_i[CTRL_RESUME_BIT];
                bank_rst_r              <= wb_dat_i[CTRL_BANK_RST_BIT];
            end
        end
    end

    // one enable bit: module enable in device mode, frame marker enable in host mode
    assign bank_pointer_reset = bank_rst_r;
    assign module_enable      = ctrl_r[CTRL_EN_BIT];
    assign sof_on             = host_mode && ctrl_r[CTRL_EN_BIT];
    assign resume_active      = ctrl_r[CTRL_RESUME_BIT];

    // threshold and table page: only the low byte holds state
    // page bit 0 is never written; it reads back as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thresh_r <= THRESH_RST;
            page_r   <= PAGE_RST;
        end else if (ce) begin
            if (wr_thresh) begin
                thresh_r <= wb_dat_i[7:0];
            end
            if (wr_page) begin
                page_r[PAGE_MSB:PAGE_LSB] <= wb_dat_i[PAGE_MSB:PAGE_LSB];
            end
        end
    end

    // low nine address bits stay zero: the table sits on a 512-byte boundary
    always_comb begin
        table_base_addr                  = '0;
        table_base_addr[31:16]           = table_base_upper;
        table_base_addr[BASE_MSB:BASE_LSB] = page_r[PAGE_MSB:PAGE_LSB];
    end

    // frame timer runs only while frame markers are on, restarts from a full frame
    // an idle timer holds zero, so the first marker follows enable at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_cnt_r <= '0;
            sof_r       <= 1'b0;
        end else if (ce) begin
            sof_r <= 1'b0;
            if (!sof_on) begin
                frame_cnt_r <= '0;
            end else if (frame_cnt_r == '0) begin
                frame_cnt_r <= FW'(FRAME_LEN - 1);
                sof_r       <= 1'b1;
            end else begin
                frame_cnt_r <= frame_cnt_r - FW'(1);
            end
        end
    end

    assign frame_marker_pulse = sof_r;

    // guard band in clock cycles; 32 bits wide so a large threshold cannot wrap
    assign guard_cycles = 32'(thresh_r) * 32'(BYTE_CYCLES);
    assign frame_left   = 32'(frame_cnt_r);

    // no new transaction once less frame time is left than the guard band
    always_comb begin
        start_allowed = 1'b1;
        if (sof_on && (frame_left < guard_cycles)) begin
            start_allowed = 1'b0;
        end
    end

    // low-speed end of packet after resume drops in host mode
    // only a write that ends an active resume counts; a repeated 0 sends nothing
    assign resume_drop = host_mode && wr_ctrl && ctrl_r[CTRL_RESUME_BIT]
        && !wb_dat_i[CTRL_RESUME_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eop_cnt_r <= '0;
        end else if (ce) begin
            if (resume_drop) begin
                eop_cnt_r <= EW'(LS_EOP_CYCLES);
            end else if (eop_cnt_r != '0) begin
                eop_cnt_r <= eop_cnt_r - EW'(1);
            end
        end
    end

    // active from the cycle after the clearing write, for the whole count
    assign ls_eop_active = (eop_cnt_r != '0);

    // bus answer: ack one cycle after the request, dropped the cycle after
    // ce low freezes ack as well, so a stalled request is simply answered later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= bus_req && !ack_r;
        end
    end

    // read byte; unmapped offsets read zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit(wb_adr_i, STAT_OFS)) begin
            rd_byte = head;
        end else if (hit(wb_adr_i, CTRL_OFS)) begin
            rd_byte = ctrl_r;
        end else if (hit(wb_adr_i, THRESH_OFS)) begin
            rd_byte = thresh_r;
        end else if (hit(wb_adr_i, PAGE_OFS)) begin
            rd_byte = {page_r[PAGE_MSB:PAGE_LSB], 1'b0};
        end else if (hit(wb_adr_i, FLAGS_OFS)) begin
            rd_byte[FLAG_TRN_BIT] = transaction_done_flag;
        end
    end

    // read word registered at the edge that raises ack so it stands for the whole cycle ack is high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_r <= '0;
        end else if (ce && bus_req && !ack_r) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule : usfc_top

// File: usfc_pkg.sv
// usfc_pkg: shared constants and carrier types of the usb status fifo and control block
// assumes a 50 MHz system clock and a 32-bit classic wishbone register bus
package usfc_pkg;

    // register byte offsets
    localparam logic [7:0] STAT_OFS   = 8'h00;
    localparam logic [7:0] CTRL_OFS   = 8'h04;
    localparam logic [7:0] THRESH_OFS = 8'h08;
    localparam logic [7:0] PAGE_OFS   = 8'h0c;
    localparam logic [7:0] FLAGS_OFS  = 8'h10;

    // status entry field positions
    localparam int STAT_EP_LSB  = 4;
    localparam int STAT_EP_MSB  = 7;
    localparam int STAT_DIR_BIT = 3;
    localparam int STAT_PPB_BIT = 2;

    // control field positions
    localparam int CTRL_EN_BIT       = 0;
    localparam int CTRL_BANK_RST_BIT = 1;
    localparam int CTRL_RESUME_BIT   = 2;

    // interrupt flag position
    localparam int FLAG_TRN_BIT = 3;

    // table page field, base address alignment
    localparam int PAGE_LSB   = 1;
    localparam int PAGE_MSB   = 7;
    localparam int BASE_LSB   = 9;
    localparam int BASE_MSB   = 15;

    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'h00;
    localparam logic [7:0] PAGE_RST   = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int FRAME_NS      = 1000000;
    localparam int FRAME_CYCLES  = FRAME_NS / CLK_PERIOD_NS;
    localparam int BYTE_TIME_NS  = 667;
    localparam int BYTE_CYCLES   = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LS_EOP_NS     = 1334;
    localparam int LS_EOP_CYCLES = (LS_EOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic [3:0] endpoint;
        logic       tx;
        logic       odd;
    } usfc_xfer_t;

    typedef struct packed {
        logic [3:0] last_endpoint_number;
        logic       last_direction;
        logic       last_bank_indicator;
        logic [1:0] unused;
    } usfc_stat_t;

endpackage : usfc_pkg

// File: usfc_assertions.sv
// usfc_checker: port checks for usfc_top
// assumes flag-clear writes carry sel[0] and a master that holds its request until ack
`timescale 1ns/1ps
module usfc_checker
    import usfc_pkg::*;
#(parameter int FRAME_LEN = FRAME_CYCLES, parameter int DEPTH = FIFO_DEPTH) (
    // bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // fifo and control
    input wire logic        host_mode,
    input wire logic        xfer_done,
    input wire logic        status_fifo_full,
    input wire logic        transaction_done_flag,
    input wire logic        module_enable,
    input wire logic        bank_pointer_reset,
    input wire logic        frame_marker_pulse,
    input wire logic        ls_eop_active
);
    logic [2:0] cnt_r;
    logic       run_r;
    int         gap_r, eop_r;
    // a pop is the flag-clear write seen at its ack edge
    wire pop = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == FLAGS_OFS
        && wb_dat_i[FLAG_TRN_BIT];
    wire push = xfer_done && (cnt_r != 3'(DEPTH) || pop);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {cnt_r, run_r, gap_r, eop_r} <= '0;
        end else if (ce) begin
            cnt_r <= cnt_r + 3'(push) - 3'(pop && cnt_r != 3'h0);
            // gap is only trusted once a full frame ran without a break
            run_r <= host_mode && module_enable && (run_r || frame_marker_pulse);
            gap_r <= frame_marker_pulse ? 0 : gap_r + 1;
            eop_r <= ls_eop_active ? eop_r + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_HI_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("high bits set");
    AST_FLAG: assert property (transaction_done_flag == (cnt_r != 3'h0))
        else $error("flag vs count");
    AST_FULL: assert property (status_fifo_full == (cnt_r == 3'(DEPTH)))
        else $error("full vs count");
    AST_BANK_RST: assert property (bank_pointer_reset |->
        $past(wb_we_i && wb_dat_i[CTRL_BANK_RST_BIT]) ##1 !bank_pointer_reset) else $error("bank");
    AST_FRAME_GAP: assert property (frame_marker_pulse && run_r |-> gap_r == FRAME_LEN - 1)
        else $error("frame gap");
    AST_EOP_LEN: assert property ($fell(ls_eop_active) |-> eop_r == LS_EOP_CYCLES)
        else $error("eop length");
    cover property (status_fifo_full);
    cover property (frame_marker_pulse && run_r);
    cover property ($fell(ls_eop_active));
endmodule : usfc_checker

// File: usfc_engine.sv
// usfc_engine: stand-in for the packet engine reporting finished transfers
// assumes the bench raises fire for each transfer it wants reported
`timescale 1ns/1ps
module usfc_engine
    import usfc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // request and report
    input  wire logic       fire,
    input  wire usfc_xfer_t fire_info,
    output logic            xfer_done,
    output usfc_xfer_t      xfer_info
);
    // info is scrambled outside its strobe so stale values cannot pass
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_done <= 1'b0;
            xfer_info <= '0;
        end else begin
            xfer_done <= fire;
            xfer_info <= fire ? fire_info : ~xfer_info;
        end
    end
endmodule : usfc_engine

// File: usfc_bench.sv
// usfc_bench: register, fifo, frame and resume tests for usfc_top
// assumes usfc_engine on the engine side and a short frame
`timescale 1ns/1ps
module usfc_bench
    import usfc_pkg::*;
;
    localparam int FLEN = 200;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, host = 1'b0;
    logic        fire = 1'b0, xdone, ack, full, flag, men, bpr, fmp, sok, res, eop;
    logic        ce = 1'b1;
    logic [3:0]  sel = 4'hf;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, q, dat_o, base;
    logic [15:0] upper = 16'ha5c3;
    usfc_xfer_t  finfo = '0, xinfo;
    logic [7:0]  thr[4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
    int          err_count = 0, samples_checked = 0, n, lo, fm, bp = 0;
    initial forever #10 clk = ~clk;
    usfc_top #(.FRAME_LEN(FLEN)) dut (
        .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .host_mode(host), .xfer_done(xdone), .xfer_info(xinfo), .table_base_upper(upper),
        .status_fifo_full(full), .transaction_done_flag(flag), .module_enable(men),
        .bank_pointer_reset(bpr), .frame_marker_pulse(fmp), .start_allowed(sok),
        .resume_active(res), .ls_eop_active(eop), .table_base_addr(base));
    usfc_engine eng (.clk(clk), .rst(rst), .fire(fire), .fire_info(finfo), .xfer_done(xdone),
        .xfer_info(xinfo));
    always @(posedge clk) if (bpr === 1'b1) bp++;
    task automatic close_out;
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            err_count++;
            close_out();
        end
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdc
    task automatic tally(input int cycles);
        lo = 0;
        fm = 0;
        n = 0;
        repeat (cycles) begin
            @(posedge clk);
            lo += int'(sok === 1'b0);
            fm += int'(fmp === 1'b1);
            n += int'(eop === 1'b1);
        end
    endtask : tally
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc(CTRL_OFS, 32'h0);
        rdc(8'h1c, 32'h0);
        wb(1'b1, PAGE_OFS, 32'hffff_ffff);
        rdc(PAGE_OFS, 32'h0000_00fe);
        chk(base, {upper, 7'h7f, 9'h000});
        foreach (thr[i]) begin
            wb(1'b1, THRESH_OFS, {24'hff_ffff, thr[i]});
            rdc(THRESH_OFS, {24'h0, thr[i]});
        end
        // a write without byte lane 0 must leave the low byte alone
        sel <= 4'he;
        wb(1'b1, THRESH_OFS, 32'h0000_0055);
        sel <= 4'hf;
        rdc(THRESH_OFS, {24'h0, thr[3]});
        // five back-to-back transfers; the last meets a full fifo
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fire <= 1'b1;
            finfo <= {4'(15 - 3 * i), i[0], i[1]};
        end
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(full), 32'h1);
        for (int i = 0; i < 4; i++) begin
            chk(32'(flag), 32'h1);
            rdc(STAT_OFS, {24'h0, 4'(15 - 3 * i), i[0], i[1], 2'b00});
            wb(1'b1, FLAGS_OFS, 32'h1 << FLAG_TRN_BIT);
        end
        @(posedge clk);
        chk(32'(flag), 32'h0);
        // with ce low a reported transfer must not enter the fifo
        ce <= 1'b0;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        chk(32'(flag), 32'h0);
        wb(1'b1, CTRL_OFS, 32'h3);
        rdc(CTRL_OFS, 32'h1);
        chk(32'(men), 32'h1);
        wb(1'b1, CTRL_OFS, 32'h0);
        @(posedge clk);
        chk(32'(men), 32'h0);
        chk(32'(bp), 32'h1);
        host <= 1'b1;
        wb(1'b1, THRESH_OFS, 32'h2);
        wb(1'b1, CTRL_OFS, 32'h1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fmp !== 1'b1 && n < 2 * FLEN);
        if (n >= 2 * FLEN) begin
            err_count++;
            close_out();
        end
        tally(FLEN);
        chk(32'(fm), 32'h1);
        chk(32'(lo), 32'(2 * BYTE_CYCLES));
        // resume held a few cycles only; a millisecond hold would dominate the run
        wb(1'b1, CTRL_OFS, 32'h4);
        rdc(CTRL_OFS, 32'h4);
        chk(32'(res), 32'h1);
        wb(1'b1, CTRL_OFS, 32'h0);
        tally(100);
        chk(32'(n), 32'(LS_EOP_CYCLES));
        close_out();
    end
    initial begin
        #1_000_000;
        err_count++;
        close_out();
    end
endmodule : usfc_bench
bind usfc_top usfc_checker #(.FRAME_LEN(FRAME_LEN), .DEPTH(DEPTH)) chk (.clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_mode, .xfer_done,
    .status_fifo_full, .transaction_done_flag, .module_enable, .bank_pointer_reset,
    .frame_marker_pulse, .ls_eop_active, .ce);
